// [encoder_position_defines.svh]
/*
  attribute numbers, reset values and transfer lengths of the
  encoder position object; assumes byte-wide attribute transfers
*/
`ifndef ENCODER_POSITION_DEFINES_SVH
`define ENCODER_POSITION_DEFINES_SVH

// ----------------------------------------
// class attribute numbers
// ----------------------------------------
`define ATTR_REVISION  8'h01
`define ATTR_MAX_INST  8'h02

// ----------------------------------------
// instance attribute numbers
// ----------------------------------------
`define ATTR_NUM_ATTRS 8'h64
`define ATTR_DIRECTION 8'h66
`define ATTR_SCALING   8'h67
`define ATTR_UNITS     8'h68
`define ATTR_RANGE     8'h69
`define ATTR_PRESET    8'h6a
`define ATTR_POSITION  8'h6b
`define ATTR_STEPS     8'h6c
`define ATTR_REVS      8'h6d
`define ATTR_ALARM     8'h6e
`define ATTR_VARIANT   8'h6f
`define ATTR_VERSION   8'h70
`define ATTR_OFFSET    8'h71

// ----------------------------------------
// values and lengths
// ----------------------------------------
`define CLASS_REVISION_VAL 16'h0001
`define DIRECTION_RST      1'b0
`define SCALING_RST        1'b0
`define OFFSET_RST         32'h00000000
`define PRESET_NONE        32'hffffffff
`define LEN_NONE           3'h0
`define LEN_BYTE           3'h1
`define LEN_HALF           3'h2
`define LEN_WORD           3'h4

`endif

// [encoder_position_pkg.sv]
/*
  types of the encoder position object;
  assumes nothing of its surroundings
*/
package encoder_position_pkg;

  // ----------------------------------------
  // transfer sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } xfer_state_e;

  typedef logic [7:0] attr_id_t;

endpackage

// [encoder_position_attributes.sv]
/*
  attribute set of the encoder position object: get of class
  and instance attributes, set of instance ones, over a byte-serial port, count
  direction, scaling, preset offset and position output.
  assumes a synchronous physical position count and one master
  that keeps the preset order and standstill conditions.
*/
// Overview of operation
// - class revision reads fixed 16-bit value
// - class attribute 2 reports highest instance
// - attribute 100 returns implemented attribute count
// - direction bit: 0 clockwise, 1 counter-clockwise
// - direction resets to clockwise
// - scaling bit 1 converts position by scaling
// - scaling resets to disabled
// - units per turn limited, defaults physical
// - scaled position is position times units/steps
// - total range is writable 32-bit step count
// - preset write makes position equal preset
// - signed offset readable, shifts every position
// - attribute 108 reports physical steps per turn
// - attribute 109 reports revolution count
// - alarm attribute reads alarm state
// - attribute 111 reports variant code
// - version word: profile low, software high
// - offset is preset minus current position
// - all-ones preset clears offset
// - direction change, switching scaling on, or new units or range discards preset
`timescale 1ns/1ps
`include "encoder_position_defines.svh"

module encoder_position_attributes
  import encoder_position_pkg::*;
#(
  parameter int unsigned STEPS_PER_TURN = 8192,
  parameter int unsigned TURN_COUNT     = 4096,
  parameter logic [7:0]  ATTR_TOTAL     = 8'h0d,
  parameter logic [15:0] HIGHEST_INST   = 16'h0001,
  parameter logic [15:0] VARIANT_CODE   = 16'h005a, // arbitrary value
  parameter logic [15:0] PROFILE_VER    = 16'h0100,
  parameter logic [15:0] SOFTWARE_VER   = 16'h0100
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [31:0] phys_pos_in,
  input  wire logic        alarm_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_class_in,
  input  wire logic        cmd_write_in,
  input  wire attr_id_t    attr_id_in,
  input  wire logic        wr_valid_in,
  input  wire logic [7:0]  wr_byte_in,
  output logic             cmd_ready_out,
  output logic             rd_valid_out,
  output logic [7:0]       rd_byte_out,
  output logic             rd_last_out,
  output logic             done_out,
  output logic             error_out,
  output logic [31:0]      position_out
);

  // ----------------------------------------
  // derived constants and checks
  // ----------------------------------------
  localparam longint unsigned SPAN64 =
    longint'(STEPS_PER_TURN) * longint'(TURN_COUNT);
  localparam logic [31:0] STEPS32 = STEPS_PER_TURN[31:0];
  localparam logic [31:0] SPAN32  = SPAN64[31:0];
  localparam logic [63:0] STEPS64 = {32'h0, STEPS32};
  localparam logic [15:0] TURNS16 = TURN_COUNT[15:0];

  // refuse geometries whose span does not fit the 32-bit position
  if (STEPS_PER_TURN < 1 || TURN_COUNT < 1 || TURN_COUNT > 65535 ||
      SPAN64 > 64'h00000000ffffffff) begin : g_bad_geometry
    $error("encoder geometry not supported");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  xfer_state_e state;
  attr_id_t    cur_id;
  logic [2:0]  xfer_len;
  logic [2:0]  xfer_cnt;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic        count_direction;
  logic        scaling_enable;
  logic [31:0] units_per_turn;
  logic [31:0] total_range;
  logic [31:0] preset_value;
  logic [31:0] position_offset;
  logic [31:0] base_pos;
  logic [31:0] position_value;

  // ----------------------------------------
  // attribute decode
  // ----------------------------------------
  // byte length of an attribute, zero when not implemented
  function automatic logic [2:0] attr_len(input logic cls,
                                          input attr_id_t id);
    attr_len = `LEN_NONE;
    if (cls) begin
      if (id == `ATTR_REVISION || id == `ATTR_MAX_INST) begin
        attr_len = `LEN_HALF;
      end
    end else begin
      case (id)
        `ATTR_NUM_ATTRS, `ATTR_DIRECTION, `ATTR_SCALING,
        `ATTR_ALARM:                       attr_len = `LEN_BYTE;
        `ATTR_REVS, `ATTR_VARIANT:         attr_len = `LEN_HALF;
        `ATTR_UNITS, `ATTR_RANGE, `ATTR_PRESET, `ATTR_POSITION,
        `ATTR_STEPS, `ATTR_VERSION,
        `ATTR_OFFSET:                      attr_len = `LEN_WORD;
        default:                           attr_len = `LEN_NONE;
      endcase
    end
  endfunction

  // only the five parameter attributes take a set request
  function automatic logic attr_writable(input logic cls,
                                         input attr_id_t id);
    attr_writable = !cls &&
      (id == `ATTR_DIRECTION || id == `ATTR_SCALING ||
       id == `ATTR_UNITS || id == `ATTR_RANGE || id == `ATTR_PRESET);
  endfunction

  // value returned by a get request
  logic [31:0] get_word;
  always_comb begin
    get_word = 32'h0;
    if (cmd_class_in) begin
      if (attr_id_in == `ATTR_REVISION) begin
        get_word = {16'h0, `CLASS_REVISION_VAL};
      end else if (attr_id_in == `ATTR_MAX_INST) begin
        get_word = {16'h0, HIGHEST_INST};
      end
    end else begin
      case (attr_id_in)
        `ATTR_NUM_ATTRS: get_word = {24'h0, ATTR_TOTAL};
        `ATTR_DIRECTION: get_word = {31'h0, count_direction};
        `ATTR_SCALING:   get_word = {31'h0, scaling_enable};
        `ATTR_UNITS:     get_word = units_per_turn;
        `ATTR_RANGE:     get_word = total_range;
        `ATTR_PRESET:    get_word = preset_value;
        `ATTR_POSITION:  get_word = position_value;
        `ATTR_STEPS:     get_word = STEPS32;
        `ATTR_REVS:      get_word = {16'h0, TURNS16};
        `ATTR_ALARM:     get_word = {31'h0, alarm_in};
        `ATTR_VARIANT:   get_word = {16'h0, VARIANT_CODE};
        `ATTR_VERSION:   get_word = {SOFTWARE_VER, PROFILE_VER};
        `ATTR_OFFSET:    get_word = position_offset;
        default:         get_word = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // request acceptance and write assembly
  // ----------------------------------------
  logic [2:0]  req_len;
  logic        req_ok;
  logic        rd_acc;
  logic        wr_acc;
  logic        commit;
  logic [31:0] next_word;
  logic        range_err;

  assign cmd_ready_out = (state == ST_IDLE);
  assign req_len = attr_len(cmd_class_in, attr_id_in);
  assign req_ok = cmd_valid_in && cmd_ready_out && req_len != `LEN_NONE;
  assign rd_acc = req_ok && !cmd_write_in;
  assign wr_acc = req_ok && cmd_write_in &&
                  attr_writable(cmd_class_in, attr_id_in);

  // incoming byte lands at its lane, lsb first
  assign next_word = wr_word |
    ({24'h0, wr_byte_in} << {xfer_cnt[1:0], 3'b000});
  assign commit = (state == ST_WRITE) && wr_valid_in &&
                  (xfer_cnt == xfer_len - 3'h1);

  // out-of-range values are refused and change nothing
  always_comb begin
    range_err = 1'b0;
    unique case (cur_id)
      `ATTR_UNITS:  range_err = next_word > STEPS32;
      `ATTR_RANGE:  range_err = next_word > SPAN32;
      `ATTR_PRESET: range_err = next_word != `PRESET_NONE &&
                                next_word > total_range;
      default:      range_err = 1'b0;
    endcase
  end

  logic set_ok;
  assign set_ok = commit && !range_err;

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state    <= ST_IDLE;
      cur_id   <= 8'h00;
      xfer_len <= `LEN_NONE;
      xfer_cnt <= 3'h0;
      wr_word  <= 32'h0;
      rd_word  <= 32'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          xfer_cnt <= 3'h0;
          wr_word  <= 32'h0;
          cur_id   <= attr_id_in;
          xfer_len <= req_len;
          rd_word  <= get_word;
          if (rd_acc) begin
            state <= ST_READ;
          end else if (wr_acc) begin
            state <= ST_WRITE;
          end
        end
        ST_READ: begin
          // shift the next byte down, lsb first
          rd_word  <= {8'h00, rd_word[31:8]};
          xfer_cnt <= xfer_cnt + 3'h1;
          if (xfer_cnt == xfer_len - 3'h1) begin
            state <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (wr_valid_in) begin
            wr_word  <= next_word;
            xfer_cnt <= xfer_cnt + 3'h1;
            if (commit) begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign rd_valid_out = (state == ST_READ);
  assign rd_byte_out  = rd_word[7:0];
  assign rd_last_out  = rd_valid_out && (xfer_cnt == xfer_len - 3'h1);

  // completion and error pulses
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out  <= 1'b0;
      error_out <= 1'b0;
    end else begin
      done_out  <= rd_last_out || commit ||
                   (cmd_valid_in && cmd_ready_out && !rd_acc && !wr_acc);
      error_out <= (commit && range_err) ||
                   (cmd_valid_in && cmd_ready_out && !rd_acc && !wr_acc);
    end
  end

  // ----------------------------------------
  // parameter attributes
  // ----------------------------------------
  logic clear_preset;

  // a direction change, switching scaling on, or a new units or range value makes the preset stale
  always_comb begin
    clear_preset = 1'b0;
    if (set_ok) begin
      unique case (cur_id)
        `ATTR_DIRECTION: clear_preset = next_word[0] != count_direction;
        `ATTR_SCALING:   clear_preset = next_word[0] && !scaling_enable;
        `ATTR_UNITS:     clear_preset = next_word != units_per_turn;
        `ATTR_RANGE:     clear_preset = next_word != total_range;
        `ATTR_PRESET:    clear_preset = next_word == `PRESET_NONE;
        default:         clear_preset = 1'b0;
      endcase
    end
  end

  // direction and scaling control bits
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_direction <= `DIRECTION_RST;
      scaling_enable  <= `SCALING_RST;
    end else if (set_ok) begin
      if (cur_id == `ATTR_DIRECTION) begin
        count_direction <= next_word[0];
      end
      if (cur_id == `ATTR_SCALING) begin
        scaling_enable <= next_word[0];
      end
    end
  end

  // scaling parameters
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      units_per_turn <= STEPS32;
      total_range    <= SPAN32;
    end else if (set_ok) begin
      if (cur_id == `ATTR_UNITS) begin
        units_per_turn <= next_word;
      end
      if (cur_id == `ATTR_RANGE) begin
        total_range <= next_word;
      end
    end
  end

  // ----------------------------------------
  // position path
  // ----------------------------------------
  logic [31:0] dir_pos;
  logic [63:0] scale_prod;
  logic [63:0] scale_quot;

  // counter-clockwise mirrors the count over the full span
  assign dir_pos = count_direction ?
                   (SPAN32 - 32'h1 - phys_pos_in) : phys_pos_in;
  // scale_quot is the position times units per turn over physical steps
  assign scale_prod = {32'h0, dir_pos} * {32'h0, units_per_turn};
  assign scale_quot = scale_prod / STEPS64;

  // directed, optionally scaled position before the offset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base_pos <= 32'h0;
    end else begin
      base_pos <= scaling_enable ? scale_quot[31:0] : dir_pos;
    end
  end

  // preset and signed offset; standstill is the master's duty
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      preset_value    <= `PRESET_NONE;
      position_offset <= `OFFSET_RST;
    end else if (clear_preset) begin
      preset_value    <= `PRESET_NONE;
      position_offset <= `OFFSET_RST;
    end else if (set_ok && cur_id == `ATTR_PRESET) begin
      preset_value    <= next_word;
      position_offset <= next_word - base_pos;
    end
  end

  // output position carries the offset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      position_value <= 32'h0;
    end else begin
      position_value <= base_pos + position_offset;
    end
  end

  assign position_out = position_value;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic pre_set;
  assign pre_set = set_ok && cur_id == `ATTR_PRESET &&
                   next_word != `PRESET_NONE;

  property p_preset_pos;
    @(posedge clk_in) disable iff (!rstn_in)
    pre_set ##1 $stable(base_pos)
      |=> position_value == $past(next_word, 2);
  endproperty
  a_preset_pos: assert property (p_preset_pos)
    else $error("position not equal to preset");

  property p_preset_cancel;
    @(posedge clk_in) disable iff (!rstn_in)
    set_ok && cur_id == `ATTR_PRESET && next_word == `PRESET_NONE
      |=> position_offset == 32'h0 ##1 position_value == $past(base_pos);
  endproperty
  a_preset_cancel: assert property (p_preset_cancel)
    else $error("all-ones preset did not clear offset");

  property p_dir_discard;
    @(posedge clk_in) disable iff (!rstn_in)
    set_ok && cur_id == `ATTR_DIRECTION &&
    next_word[0] != count_direction
      |=> position_offset == 32'h0 && preset_value == `PRESET_NONE;
  endproperty
  a_dir_discard: assert property (p_dir_discard)
    else $error("direction change kept preset");

  property p_offset_add;
    @(posedge clk_in) disable iff (!rstn_in)
    ##1 position_value == $past(base_pos) + $past(position_offset);
  endproperty
  a_offset_add: assert property (p_offset_add)
    else $error("offset not applied to position");

  property p_cw_plain;
    @(posedge clk_in) disable iff (!rstn_in)
    !count_direction && !scaling_enable |=> base_pos == $past(phys_pos_in);
  endproperty
  a_cw_plain: assert property (p_cw_plain)
    else $error("unscaled clockwise position wrong");

  property p_word_read;
    @(posedge clk_in) disable iff (!rstn_in)
    rd_acc && req_len == `LEN_WORD
      |=> rd_valid_out [*4] ##1 !rd_valid_out && done_out;
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("word read not four bytes");

  property p_pos_lsb;
    @(posedge clk_in) disable iff (!rstn_in)
    rd_acc && attr_id_in == `ATTR_POSITION
      |=> rd_byte_out == $past(position_value[7:0])
      ##1 rd_byte_out == $past(rd_word[15:8]);
  endproperty
  a_pos_lsb: assert property (p_pos_lsb)
    else $error("position bytes out of order");

  property p_class_rev;
    @(posedge clk_in) disable iff (!rstn_in)
    rd_acc && cmd_class_in && attr_id_in == `ATTR_REVISION
      |=> rd_byte_out == 8'h01 ##1 rd_byte_out == 8'h00 && rd_last_out;
  endproperty
  a_class_rev: assert property (p_class_rev)
    else $error("class revision wrong");

  property p_alarm_read;
    @(posedge clk_in) disable iff (!rstn_in)
    rd_acc && !cmd_class_in && attr_id_in == `ATTR_ALARM
      |=> rd_byte_out == {7'h0, $past(alarm_in)} && rd_last_out;
  endproperty
  a_alarm_read: assert property (p_alarm_read)
    else $error("alarm attribute wrong");

  property p_units_limit;
    @(posedge clk_in) disable iff (!rstn_in)
    commit && cur_id == `ATTR_UNITS && next_word > STEPS32
      |=> error_out && $stable(units_per_turn);
  endproperty
  a_units_limit: assert property (p_units_limit)
    else $error("oversized units per turn accepted");

  property p_ro_refused;
    @(posedge clk_in) disable iff (!rstn_in)
    cmd_valid_in && cmd_ready_out && cmd_write_in &&
    !cmd_class_in && attr_id_in == `ATTR_STEPS
      |=> error_out && done_out && cmd_ready_out;
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to read-only attribute taken");

  c_preset: cover property (@(posedge clk_in) disable iff (!rstn_in)
    pre_set);
  c_scaled: cover property (@(posedge clk_in) disable iff (!rstn_in)
    scaling_enable && count_direction);
  c_word_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
    rd_acc && req_len == `LEN_WORD);
  c_range_err: cover property (@(posedge clk_in) disable iff (!rstn_in)
    commit && range_err);

endmodule // encoder_position_attributes

// [fieldbus_master_model.sv]
/*
  fieldbus master model: issues get and set requests on the byte
  port of the position object; assumes it shares the device clock
*/
`timescale 1ns/1ps

module fieldbus_master_model (
  input  wire logic       clk_in,
  input  wire logic       cmd_ready_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_byte_in,
  input  wire logic       done_in,
  input  wire logic       error_in,
  output logic            cmd_valid_out,
  output logic            cmd_class_out,
  output logic            cmd_write_out,
  output logic [7:0]      attr_id_out,
  output logic            wr_valid_out,
  output logic [7:0]      wr_byte_out
);
  // quiet bus at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_class_out = 1'b0;
    cmd_write_out = 1'b0;
    attr_id_out   = 8'h00;
    wr_valid_out  = 1'b0;
    wr_byte_out   = 8'h00;
  end

  // wait for idle, hold the strobe across the taking edge
  task automatic request(input logic cls, input logic wr, input logic [7:0] id);
    int n;
    n = 0;
    @(negedge clk_in);
    while (cmd_ready_in !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    cmd_valid_out = 1'b1;
    cmd_class_out = cls;
    cmd_write_out = wr;
    attr_id_out   = id;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    attr_id_out   = ~id; // released id and class do not keep their value
    cmd_class_out = ~cls;
  endtask

  // get: gather bytes lsb first until done
  task automatic get_attr(input logic cls, input logic [7:0] id, output logic [31:0] val, output logic err);
    int k;
    int n;
    k = 0;
    n = 0;
    val = 32'h00000000;
    request(cls, 1'b0, id);
    while (done_in !== 1'b1 && n < 20) begin
      if (rd_valid_in === 1'b1 && k < 4) begin
        val[8*k +: 8] = rd_byte_in;
        k++;
      end
      @(negedge clk_in);
      n++;
    end
    // a transfer that never finishes shows as unknown to the checks
    if (n >= 20) begin
      val = 32'hxxxxxxxx;
      err = 1'bx;
    end else begin
      err = error_in;
    end
  endtask

  // set: send len bytes lsb first, one per cycle, then wait for done
  task automatic set_attr(input logic [7:0] id, input int len, input logic [31:0] val, output logic err);
    int k;
    int n;
    k = 0;
    n = 0;
    request(1'b0, 1'b1, id);
    while (done_in !== 1'b1 && n < 20) begin
      wr_valid_out = (k < len);
      wr_byte_out  = (k < len) ? val[8*k +: 8] : ~wr_byte_out;
      k++;
      @(negedge clk_in);
      n++;
    end
    wr_valid_out = 1'b0;
    err = (n >= 20) ? 1'bx : error_in;
  endtask
endmodule // fieldbus_master_model

// [tb.sv]
/*
  testbench of the encoder position attributes: scenario tasks drive
  the byte port through the master model; assumes small geometry
*/
`timescale 1ns/1ps

module tb;
  localparam int unsigned STEPS = 16;
  localparam int unsigned TURNS = 4;
  logic        clk_in;
  logic        rstn_in;
  logic [31:0] phys_pos_in;
  logic        alarm_in;
  logic        cmd_valid, cmd_class, cmd_write, wr_valid;
  logic [7:0]  attr_id, wr_byte, rd_byte;
  logic        cmd_ready, rd_valid, rd_last, done, error;
  logic [31:0] position_out;
  logic [31:0] val;
  logic        err;
  int          err_total;
  int          n_tests;

  encoder_position_attributes #(.STEPS_PER_TURN(STEPS), .TURN_COUNT(TURNS)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .phys_pos_in(phys_pos_in), .alarm_in(alarm_in),
    .cmd_valid_in(cmd_valid), .cmd_class_in(cmd_class), .cmd_write_in(cmd_write),
    .attr_id_in(attr_id), .wr_valid_in(wr_valid), .wr_byte_in(wr_byte),
    .cmd_ready_out(cmd_ready), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte),
    .rd_last_out(rd_last), .done_out(done), .error_out(error), .position_out(position_out));

  fieldbus_master_model master_u (
    .clk_in(clk_in), .cmd_ready_in(cmd_ready), .rd_valid_in(rd_valid), .rd_byte_in(rd_byte),
    .done_in(done), .error_in(error), .cmd_valid_out(cmd_valid), .cmd_class_out(cmd_class),
    .cmd_write_out(cmd_write), .attr_id_out(attr_id), .wr_valid_out(wr_valid), .wr_byte_out(wr_byte));

  // ----------------------------------------
  // clock and compare tasks
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // new count reaches position_out two edges later
  task automatic move_to(input logic [31:0] p);
    @(negedge clk_in);
    phys_pos_in = p;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic set_ok(input logic [7:0] id, input int len, input logic [31:0] v);
    master_u.set_attr(id, len, v, err);
    chk_flag(err, 1'b0);
    repeat (2) @(negedge clk_in);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_table();
    logic [7:0]  ids [13] = '{8'h01, 8'h02, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6c,
                              8'h6d, 8'h6f, 8'h70, 8'h71};
    logic [31:0] exp [13] = '{32'h1, 32'h1, 32'h0d, 32'h0, 32'h0, 32'h10, 32'h40, 32'hffffffff,
                              32'h10, 32'h4, 32'h5a, 32'h01000100, 32'h0};
    for (int i = 0; i < 13; i++) begin
      master_u.get_attr(i < 2, ids[i], val, err);
      chk(val, exp[i]);
      chk_flag(err, 1'b0);
    end
  endtask

  task automatic t_alarm();
    alarm_in = 1'b1;
    master_u.get_attr(1'b0, 8'h6e, val, err);
    chk(val, 32'h1);
    alarm_in = 1'b0;
    master_u.get_attr(1'b0, 8'h6e, val, err);
    chk(val, 32'h0);
  endtask

  task automatic t_preset();
    move_to(32'h5);
    master_u.get_attr(1'b0, 8'h6b, val, err);
    chk(val, 32'h5);
    set_ok(8'h6a, 4, 32'h14);
    chk(position_out, 32'h14);
    master_u.get_attr(1'b0, 8'h71, val, err);
    chk(val, 32'h0f);
    master_u.set_attr(8'h6a, 4, 32'h41, err);
    chk_flag(err, 1'b1);
    move_to(32'h7);
    chk(position_out, 32'h16);
    set_ok(8'h6a, 4, 32'hffffffff);
    master_u.get_attr(1'b0, 8'h71, val, err);
    chk(val, 32'h0);
    chk(position_out, 32'h7);
  endtask

  task automatic t_direction();
    set_ok(8'h6a, 4, 32'h1e);
    set_ok(8'h66, 1, 32'h1);
    master_u.get_attr(1'b0, 8'h71, val, err);
    chk(val, 32'h0);
    chk(position_out, 32'h38);
    set_ok(8'h66, 1, 32'h0);
    chk(position_out, 32'h7);
  endtask

  task automatic t_scaling();
    set_ok(8'h68, 4, 32'h8);
    set_ok(8'h69, 4, 32'h20);
    master_u.get_attr(1'b0, 8'h69, val, err);
    chk(val, 32'h20);
    set_ok(8'h67, 1, 32'h1);
    chk(position_out, 32'h3);
    set_ok(8'h6a, 4, 32'ha);
    chk(position_out, 32'ha);
    master_u.set_attr(8'h68, 4, 32'h11, err);
    chk_flag(err, 1'b1);
    master_u.get_attr(1'b0, 8'h68, val, err);
    chk(val, 32'h8);
    // counter-clockwise with scaling on drops the preset
    set_ok(8'h66, 1, 32'h1);
    chk(position_out, 32'h1c);
    master_u.get_attr(1'b0, 8'h6a, val, err);
    chk(val, 32'hffffffff);
  endtask

  task automatic t_refuse();
    master_u.set_attr(8'h6c, 4, 32'h1, err);
    chk_flag(err, 1'b1);
    master_u.get_attr(1'b0, 8'h65, val, err);
    chk_flag(err, 1'b1);
    master_u.get_attr(1'b0, 8'h01, val, err);
    chk_flag(err, 1'b1);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_tests = 0;
    rstn_in = 1'b0;
    phys_pos_in = 32'h0;
    alarm_in = 1'b0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    t_reset_table();
    t_alarm();
    t_preset();
    t_direction();
    t_scaling();
    t_refuse();
    give_verdict();
  end

  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule // tb
